// ==== logic/ea_gen_defs.vh ====
/*
 * Constants for the effective-address generator: addressing modes, operand
 * sizes, operation classes, bit operations and address widths.
 * Assumes inclusion by bare name from logic/ files.
 */
`ifndef EA_GEN_DEFS_VH
`define EA_GEN_DEFS_VH

`define MODE_REG_DIRECT   3'h0
`define MODE_REG_INDIRECT 3'h1
`define MODE_DISP         3'h2
`define MODE_POST_INC     3'h3
`define MODE_PRE_DEC      3'h4
`define MODE_ABSOLUTE     3'h5
`define MODE_IMMEDIATE    3'h6
`define MODE_PC_REL       3'h7
`define MODE_MEM_INDIRECT 4'h8

`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2

`define CLASS_TRANSFER 2'h0
`define CLASS_ARITH    2'h1
`define CLASS_BIT      2'h2
`define CLASS_BRANCH   2'h3

`define ABS_LEN_8  2'h0
`define ABS_LEN_16 2'h1
`define ABS_LEN_24 2'h2

`define IMM_LEN_8  2'h0
`define IMM_LEN_16 2'h1
`define IMM_LEN_32 2'h2
`define IMM_LEN_2  2'h3

`define BITOP_SET     3'h0
`define BITOP_CLEAR   3'h1
`define BITOP_INVERT  3'h2
`define BITOP_TEST    3'h3
`define BITOP_STORE   3'h4
`define BITOP_STOREIN 3'h5

`define ADDR_MASK_1M  24'h0F_FFFF
`define ADDR_MASK_16M 24'hFF_FFFF
`define ABS8_UPPER    16'hFFFF
`define MEMIND_UPPER  16'h0000
`define WRITE_ONLY_READ 8'hFF
`define STEP_BYTE 32'h0000_0001
`define STEP_WORD 32'h0000_0002
`define STEP_LONG 32'h0000_0004

`endif

// ==== logic/bit_modify.v ====
/*
 * Combinational bit modifier for the read-modify-write sequence.
 * Assumes the byte read and the bit number are stable while in use.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ea_gen_defs.vh"

module bit_modify (
	input  wire [7:0] readByte,
	input  wire [2:0] bitNum,
	input  wire [2:0] bitOp,
	input  wire       carry,
	output reg  [7:0] writeByte,
	output wire       testZero
);
	wire [7:0] sel;

	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_sel
			assign sel[i] = (bitNum == i);
		end
	endgenerate

	assign testZero = ~|(readByte & sel);

	// Only the selected bit changes; the rest of the byte is kept.
	always @* begin
		case (bitOp)
			`BITOP_SET: writeByte = readByte | sel;
			`BITOP_CLEAR: writeByte = readByte & ~sel;
			`BITOP_INVERT: writeByte = readByte ^ sel;
			`BITOP_STORE: writeByte = carry ? (readByte | sel) : (readByte & ~sel);
			`BITOP_STOREIN: writeByte = carry ? (readByte & ~sel) : (readByte | sel);
			default: writeByte = readByte;
		endcase
	end
endmodule

`default_nettype wire

// ==== logic/ea_gen.v ====
/*
 * Effective-address generator with register file and bit read-modify-write
 * sequencer. Assumes a bus that answers each access with a one-cycle ack,
 * and mode pins that are static after reset.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ea_gen_defs.vh"

// Contract
// - Bit set/clear/invert/store ops read the byte, change one bit, write it back; in register direct mode they only load operand and modify no register.
// - Bit-op reads of the write-only direction register see all ones; operand still takes the raw bus data.
// - Bit ops use register direct, indirect or 8-bit absolute; bit number by immediate or register.
// - Arithmetic uses register/immediate only; transfers exclude PC-relative and memory indirect.
// - Register direct selects 8-bit half, 16-bit half or 32-bit register by size.
// - Register indirect address is the low 24 bits of the address register.
// - Displacement add_constant_op sign-extended 16-bit or 24-bit value; low 24 bits used.
// - Post-increment add_constant_op 1, 2 or 4 to the full register after access.
// - Pre-decrement subtracts 1, 2 or 4 first, writes back, uses low 24 bits.
// - 8-bit absolute gets all-ones upper bits, 16-bit sign extends, 24-bit unchanged.
// - 8-bit absolute reaches only the top 256 bytes of the space.
// - Immediates are 8, 16 or 32 bits; trap vector uses a 2-bit immediate.
// - PC-relative sign-extends 8/16-bit displacement and add_constant_op it to next-instruction address.
// - Memory indirect reads a low-page longword and uses its lower 24 bits.
// - Word, longword and branch target addresses have bit 0 forced to zero.
// - In 1-Mbyte modes the upper 4 address bits are dropped.
// - Bit clear on a read-to-clear flag counts as the required prior read.
// - Mode pins choose between 1-Mbyte and 16-Mbyte address spaces.
module ea_gen (
	input  wire        clock,
	input  wire        rst,
	input  wire        modeSelectPinHigh,
	input  wire [1:0]  modeSelectPinLow,
	input  wire        start,
	input  wire [3:0]  addrMode,
	input  wire [1:0]  opSize,
	input  wire [1:0]  opClass,
	input  wire [3:0]  regField,
	input  wire [1:0]  extLen,
	input  wire [31:0] extValue,
	input  wire [23:0] nextPc,
	input  wire        bitOpEn,
	input  wire [2:0]  bitOp,
	input  wire        bitNumFromReg,
	input  wire [2:0]  bitNumImm,
	input  wire [2:0]  bitNumReg,
	input  wire        carryIn,
	input  wire        regWriteEn,
	input  wire [2:0]  regWriteSel,
	input  wire [31:0] regWriteData,
	input  wire [23:0] dirRegAddr,
	output reg  [23:0] busAddr,
	output reg         busRead,
	output reg         busWrite,
	output reg  [7:0]  busWriteData,
	input  wire [31:0] busReadData,
	input  wire        busAck,
	output reg  [23:0] effAddr,
	output reg  [31:0] operand,
	output reg         done,
	output reg         illegal,
	output reg         testZero,
	output reg         flagReadSeen,
	output reg         wideSpace
);
	localparam ST_IDLE = 3'h0;
	localparam ST_CALC = 3'h1;
	localparam ST_READ = 3'h2;
	localparam ST_WRITE = 3'h3;
	localparam ST_DONE = 3'h4;

	reg  [31:0] regFile [0:7];
	reg  [2:0]  state;
	reg  [2:0]  modeSync1;
	reg  [2:0]  modeSync2;
	reg  [23:0] addrLatch;
	reg  [7:0]  rmwByte;
	reg         memIndPending;
	reg  [2:0]  next_state;
	reg  [23:0] next_addr;
	reg         next_illegal;
	reg         needRead;
	reg  [31:0] regSel;
	reg  [31:0] step;
	reg  [31:0] preDec;
	reg  [23:0] rawAddr;
	reg  [31:0] directVal;
	wire [7:0]  modByte;
	wire        modZero;
	wire [2:0]  bitNum;
	wire [23:0] spaceMask;
	wire [23:0] dispSum;
	wire [23:0] pcSum;
	wire [7:0]  readByteView;
	integer     k;

	assign bitNum = bitNumFromReg ? bitNumReg : bitNumImm;
	assign spaceMask = wideSpace ? `ADDR_MASK_16M : `ADDR_MASK_1M;
	assign dispSum = (regSel[23:0] + ((extLen == `ABS_LEN_16) ?
		{{8{extValue[15]}}, extValue[15:0]} : extValue[23:0]));
	assign pcSum = nextPc + ((extLen == `ABS_LEN_8) ?
		{{16{extValue[7]}}, extValue[7:0]} : {{8{extValue[15]}}, extValue[15:0]});
	assign readByteView = (addrLatch == dirRegAddr) ? `WRITE_ONLY_READ : busReadData[7:0];

	bit_modify u_mod (
		.readByte  (rmwByte),
		.bitNum    (bitNum),
		.bitOp     (bitOp),
		.carry     (carryIn),
		.writeByte (modByte),
		.testZero  (modZero)
	);

	always @* begin
		regSel = regFile[regField[2:0]];
		case (opSize)
			`SIZE_BYTE: step = `STEP_BYTE;
			`SIZE_WORD: step = `STEP_WORD;
			default: step = `STEP_LONG;
		endcase
		preDec = regSel - step;
		case (opSize)
			`SIZE_BYTE: directVal = {24'h00_0000, regField[3] ? regFile[regField[2:0]][7:0] :
				regFile[regField[2:0]][15:8]};
			`SIZE_WORD: directVal = {16'h0000, regField[3] ? regFile[regField[2:0]][31:16] :
				regFile[regField[2:0]][15:0]};
			default: directVal = regSel;
		endcase
		case (extLen)
			`ABS_LEN_8: rawAddr = {`ABS8_UPPER, extValue[7:0]};
			`ABS_LEN_16: rawAddr = {{8{extValue[15]}}, extValue[15:0]};
			default: rawAddr = extValue[23:0];
		endcase
		case (addrMode)
			{1'b0, `MODE_REG_INDIRECT}: next_addr = regSel[23:0];
			{1'b0, `MODE_DISP}: next_addr = dispSum;
			{1'b0, `MODE_POST_INC}: next_addr = regSel[23:0];
			{1'b0, `MODE_PRE_DEC}: next_addr = preDec[23:0];
			{1'b0, `MODE_ABSOLUTE}: next_addr = rawAddr;
			{1'b0, `MODE_PC_REL}: next_addr = pcSum;
			`MODE_MEM_INDIRECT: next_addr = {`MEMIND_UPPER, extValue[7:0]};
			default: next_addr = 24'h00_0000;
		endcase
		if (opSize != `SIZE_BYTE || opClass == `CLASS_BRANCH || addrMode == {1'b0, `MODE_PC_REL} ||
			addrMode == `MODE_MEM_INDIRECT)
			next_addr[0] = 1'b0;
		next_addr = next_addr & spaceMask;
		case (opClass)
			`CLASS_ARITH: next_illegal = !(addrMode == {1'b0, `MODE_REG_DIRECT} ||
				addrMode == {1'b0, `MODE_IMMEDIATE});
			`CLASS_TRANSFER: next_illegal = (addrMode == {1'b0, `MODE_PC_REL} ||
				addrMode == `MODE_MEM_INDIRECT);
			`CLASS_BIT: next_illegal = !(addrMode == {1'b0, `MODE_REG_DIRECT} ||
				addrMode == {1'b0, `MODE_REG_INDIRECT} ||
				(addrMode == {1'b0, `MODE_ABSOLUTE} && extLen == `ABS_LEN_8)) ||
				(bitNumFromReg && bitOp != `BITOP_SET && bitOp != `BITOP_CLEAR &&
				bitOp != `BITOP_INVERT && bitOp != `BITOP_TEST);
			default: next_illegal = !(addrMode == {1'b0, `MODE_PC_REL} ||
				addrMode == `MODE_MEM_INDIRECT || addrMode == {1'b0, `MODE_ABSOLUTE});
		endcase
		needRead = !(addrMode == {1'b0, `MODE_REG_DIRECT} || addrMode == {1'b0, `MODE_IMMEDIATE} ||
			(opClass == `CLASS_BRANCH && addrMode != `MODE_MEM_INDIRECT));
		next_state = state;
		case (state)
			ST_IDLE: if (start) next_state = ST_CALC;
			ST_CALC: next_state = (next_illegal || !needRead) ? ST_DONE : ST_READ;
			ST_READ: if (busAck) next_state = (bitOpEn && bitOp != `BITOP_TEST) ? ST_WRITE : ST_DONE;
			ST_WRITE: if (busAck) next_state = ST_DONE;
			ST_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			modeSync1 <= 3'h0;
			modeSync2 <= 3'h0;
			wideSpace <= 1'b0;
		end else begin
			modeSync1 <= {modeSelectPinHigh, modeSelectPinLow};
			modeSync2 <= modeSync1;
			wideSpace <= modeSync2[2] | (modeSync2[1] & modeSync2[0]);
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			for (k = 0; k < 8; k = k + 1)
				regFile[k] <= 32'h0000_0000;
		end else if (state == ST_CALC && !next_illegal && addrMode == {1'b0, `MODE_PRE_DEC}) begin
			regFile[regField[2:0]] <= preDec;
		end else if (state == ST_READ && busAck && addrMode == {1'b0, `MODE_POST_INC}) begin
			regFile[regField[2:0]] <= regSel + step;
		end else if (regWriteEn && state == ST_IDLE) begin
			regFile[regWriteSel] <= regWriteData;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			addrLatch <= 24'h00_0000;
			rmwByte <= 8'h00;
			busAddr <= 24'h00_0000;
			busRead <= 1'b0;
			busWrite <= 1'b0;
			busWriteData <= 8'h00;
			effAddr <= 24'h00_0000;
			operand <= 32'h0000_0000;
			done <= 1'b0;
			illegal <= 1'b0;
			testZero <= 1'b0;
			flagReadSeen <= 1'b0;
			memIndPending <= 1'b0;
		end else begin
			state <= next_state;
			done <= 1'b0;
			flagReadSeen <= 1'b0;
			case (state)
				ST_IDLE: begin
					busRead <= 1'b0;
					busWrite <= 1'b0;
				end
				ST_CALC: begin
					illegal <= next_illegal;
					addrLatch <= next_addr;
					effAddr <= next_addr;
					memIndPending <= (addrMode == `MODE_MEM_INDIRECT);
					if (addrMode == {1'b0, `MODE_REG_DIRECT})
						operand <= directVal;
					else if (addrMode == {1'b0, `MODE_IMMEDIATE})
						case (extLen)
							`IMM_LEN_8: operand <= {24'h00_0000, extValue[7:0]};
							`IMM_LEN_16: operand <= {16'h0000, extValue[15:0]};
							`IMM_LEN_2: operand <= {30'h0000_0000, extValue[1:0]};
							default: operand <= extValue;
						endcase
					if (!next_illegal && needRead) begin
						busAddr <= next_addr;
						busRead <= 1'b1;
					end
				end
				ST_READ: if (busAck) begin
					busRead <= 1'b0;
					rmwByte <= readByteView;
					operand <= busReadData;
					flagReadSeen <= bitOpEn;
					if (memIndPending)
						effAddr <= {busReadData[23:1], 1'b0} & spaceMask;
					if (bitOpEn && bitOp == `BITOP_TEST)
						testZero <= ~|(readByteView & (8'h01 << bitNum));
					if (bitOpEn && bitOp != `BITOP_TEST)
						busWrite <= 1'b1;
				end
				ST_WRITE: begin
					busWriteData <= modByte;
					testZero <= modZero;
					if (busAck)
						busWrite <= 1'b0;
				end
				ST_DONE: done <= 1'b1;
				default: done <= 1'b0;
			endcase
		end
	end
endmodule

`default_nettype wire

// ==== test/ea_gen_props.sv ====
/* Checker for the ea_gen ports, bound at the foot of this file.
   Assumes bus requests are held until the one-cycle ack. */
`timescale 1ns/10ps
`default_nettype none
module ea_gen_props (
	input wire logic        clock, rst, start, busRead, busWrite, busAck, done, illegal, wideSpace,
	input wire logic [1:0]  opSize, extLen,
	input wire logic [3:0]  addrMode,
	input wire logic [7:0]  busWriteData,
	input wire logic [23:0] dirRegAddr, busAddr, effAddr,
	input wire logic [31:0] busReadData
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic [7:0] rdByte;
	always @(posedge clock or posedge rst)
		if (rst)
			rdByte <= 8'h00;
		else if (busRead && busAck)
			rdByte <= busAddr == dirRegAddr ? 8'hFF : busReadData[7:0];
	done_bound_a: assert property (start |-> ##[1:60] done) else $error("no done");
	rmw_addr_a: assert property ($rose(busWrite) |-> busAddr == $past(busAddr)) else $error("write moved");
	one_bit_a: assert property (busWrite && busAck |-> $countones(busWriteData ^ rdByte) <= 1)
		else $error("byte changed");
	no_bus_a: assert property ($rose(illegal) |-> !busRead && !busWrite) else $error("bus on refusal");
	bus_trim_a: assert property (!wideSpace && busRead |-> busAddr[23:20] == 4'h0) else $error("bus untrimmed");
	ea_trim_a: assert property (done && !wideSpace |-> effAddr[23:20] == 4'h0) else $error("ea untrimmed");
	even_addr_a: assert property (done && !illegal && opSize != 2'h0 && addrMode > 4'h0 && addrMode < 4'h6
		|-> !effAddr[0]) else $error("odd address");
	abs_short_a: assert property (done && !illegal && addrMode == 4'h5 && extLen == 2'h0
		|-> &effAddr[19:8]) else $error("short absolute out of page");
endmodule
bind ea_gen ea_gen_props i_ea_gen_props (.*);
`default_nettype wire

// ==== test/bus_mem.sv ====
/* Bus memory model: acks after a delay set by slow, scrambles read data
   once an access ends. Assumes requests are held until ack. */
`timescale 1ns/10ps
`default_nettype none
module bus_mem (
	input wire logic        clock, rst, busRead, busWrite,
	input wire logic [1:0]  slow,
	input wire logic [7:0]  busWriteData,
	input wire logic [23:0] busAddr,
	output logic     [31:0] busReadData,
	output logic            busAck,
	output logic     [7:0]  lastWrite
);
	logic [2:0] waitCnt;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			waitCnt <= 3'h0;
			busAck <= 1'b0;
			busReadData <= 32'h0000_0000;
			lastWrite <= 8'h00;
		end else begin
			busAck <= 1'b0;
			busReadData <= ~busReadData;
			if (!(busRead || busWrite) || busAck)
				waitCnt <= 3'h0;
			else if (waitCnt <= {1'b0, slow})
				waitCnt <= waitCnt + 3'h1;
			else begin
				busAck <= 1'b1;
				busReadData <= {8'hA5, ~busAddr};
				if (busWrite)
					lastWrite <= busWriteData;
			end
		end
	end
endmodule
`default_nettype wire

// ==== test/tb_ea_gen.sv ====
/* Self-checking bench for ea_gen against an address model in the bench.
   Assumes bus_mem answers every bus access. */
`timescale 1ns/10ps
`default_nettype none
module tb_ea_gen;
	logic        clock = 0, rst = 1, start = 0, bitOpEn = 0, bitNumFromReg = 0, carryIn = 0, regWriteEn = 0;
	logic        modeSelectPinHigh = 0, busAck, busRead, busWrite, done, illegal, testZero, flagReadSeen, wideSpace;
	logic [1:0]  modeSelectPinLow = 0, opSize = 0, opClass = 0, extLen = 0, slow = 0;
	logic [2:0]  bitOp = 0, bitNumImm = 0, bitNumReg = 0, regWriteSel = 0, n;
	logic [3:0]  addrMode = 0, regField = 0;
	logic [7:0]  busWriteData, lastWrite, b;
	logic [23:0] nextPc = 0, dirRegAddr = 24'h0F_FF3C, busAddr, effAddr;
	logic [31:0] extValue = 0, regWriteData = 0, busReadData, operand, a, r = 0, mreg [8];
	integer      seed = 54, errCount = 0, nChecks = 0, p, i, m, c, k, fs = 0;
	ea_gen i_ea_gen (.*);
	bus_mem i_bus_mem (.*);
	always #12.5 clock = ~clock;
	always @(posedge clock)
		if (flagReadSeen === 1'b1)
			fs <= fs + 1;
	task chk(input string nm, input logic [31:0] seen, exp);
		nChecks++;
		if (seen !== exp) begin
			errCount++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", nChecks, errCount);
		if (errCount == 0 && nChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task go(input logic [3:0] md, input logic [1:0] s, cl, el, input logic [3:0] rf, input logic [31:0] ev);
		logic ill;
		logic [31:0] ex;
		integer f0;
		f0 = fs;
		@(posedge clock);
		addrMode <= md;
		opSize <= s;
		opClass <= cl;
		extLen <= el;
		regField <= rf;
		extValue <= ev;
		bitOpEn <= cl == 2'h2;
		slow <= r[18:17];
		nextPc <= r[31:8];
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		for (k = 0; k < 60 && done !== 1'b1; k++)
			@(negedge clock);
		if (k == 60) begin
			errCount++;
			results;
		end
		case (cl)
			2'h0: ill = md > 6;
			2'h1: ill = md != 0 && md != 6;
			2'h2: ill = !(md < 2 || md == 5 && el == 0) || bitNumFromReg && bitOp > 3;
			default: ill = md < 5 || md == 6;
		endcase
		a = mreg[rf[2:0]];
		case (md)
			2: a = a + (el == 1 ? {{16{ev[15]}}, ev[15:0]} : ev);
			3: if (!ill) mreg[rf[2:0]] = a + (32'h1 << s);
			4: begin
				a = a - (32'h1 << s);
				if (!ill) mreg[rf[2:0]] = a;
			end
			5: a = el == 0 ? {16'hFFFF, ev[7:0]} : el == 1 ? {{16{ev[15]}}, ev[15:0]} : ev;
			7: a = nextPc + (el == 0 ? {{24{ev[7]}}, ev[7:0]} : {{16{ev[15]}}, ev[15:0]});
			8: a = ~{16'h0000, ev[7:0]};
		endcase
		chk("illegal", illegal, ill);
		chk("flagReadSeen", fs - f0, !ill && cl == 2 && md > 0);
		ex = s == 2 ? a : s == 1 ? (rf[3] ? a[31:16] : a[15:0]) : (rf[3] ? a[7:0] : a[15:8]);
		if (!ill && md == 0 && cl != 2) chk("operand", operand, ex);
		ex = el == 0 ? ev[7:0] : el == 1 ? ev[15:0] : el == 3 ? ev[1:0] : ev;
		if (!ill && md == 6) chk("operand", operand, ex);
		if (s != 0 || cl == 3) a[0] = 1'b0;
		if (p < 3) a[23:20] = 4'h0;
		if (!ill && md > 0 && md != 6) chk("effAddr", effAddr, a[23:0]);
		b = a[23:0] == dirRegAddr ? 8'hFF : ~a[7:0];
		n = bitNumFromReg ? bitNumReg : bitNumImm;
		if (!ill && cl == 2 && md > 0) begin
			if (bitOp == 3) chk("testZero", testZero, !b[n]);
			b[n] = bitOp == 0 || bitOp == 2 && !b[n] || bitOp == 4 && carryIn || bitOp == 5 && !carryIn;
			if (bitOp != 3) chk("writeByte", lastWrite, b);
		end
	endtask
	initial begin
		for (p = 1; p < 5; p++) begin
			@(posedge clock);
			rst <= 1'b1;
			{modeSelectPinHigh, modeSelectPinLow} <= p[2:0];
			repeat (20) @(posedge clock);
			rst <= 1'b0;
			repeat (4) @(posedge clock);
			chk("wideSpace", wideSpace, p > 2);
			for (i = 0; i < 8; i++) begin
				a = i == 5 ? {8'h00, dirRegAddr} : $random(seed) & 32'hFFFF_FFFC;
				regWriteEn <= 1'b1;
				regWriteSel <= i;
				regWriteData <= a;
				mreg[i] = a;
				@(posedge clock);
			end
			regWriteEn <= 1'b0;
			for (i = 0; i < 3; i++) begin
				go(3, i, 0, 0, 2, 0);
				go(4, i, 0, 0, 2, 0);
				go(0, i, 0, 0, i == 1 ? 4'h2 : 4'hA, 0);
			end
			for (i = 0; i < 6; i++) begin
				@(posedge clock);
				bitOp <= i;
				bitNumFromReg <= 1'b0;
				bitNumImm <= i + 1;
				go(1, 0, 2, 0, 5, 0);
			end
			for (m = 0; m < 9; m++)
				for (c = 0; c < 4; c++) begin
					r = $random(seed);
					@(posedge clock);
					bitOp <= r[30:28] % 6;
					bitNumFromReg <= r[30:28] % 6 < 4 && r[5];
					bitNumImm <= r[8:6];
					bitNumReg <= r[11:9];
					carryIn <= r[12];
					go(m, c == 2 ? 0 : 1 + r[1], c, m == 2 ? 1 + r[2] : m == 7 ? r[2] : m == 6 ? r[3:2] : r[3:2] % 3,
						c == 2 ? 5 - r[4] : r[16:13], $random(seed));
				end
			$display("mode pattern %0d finished", p);
		end
		results;
	end
endmodule
`default_nettype wire
